//--- verilog/ccm_sequencer.sv
// Purpose: Sampling and channel multiplex sequencer of a three-channel CCD front end.
// Assumes: Sampling clocks are synchronous levels sampled on clk; edges found by comparison.
// Notes: Gain-stage outputs arrive as digital levels; trim values are handed to the analog path.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Six modes: three, two or one channel, each double sampling or sample-and-hold.
// - Mode comes only from configuration registers written by software.
// - Double sampling captures reference level at every reference clock falling edge.
// - Data clock falling edge captures data level on all active channels together.
// - Three-channel modes hold red, green and blue values for the current pixel.
// - Data clock rising edge sends the multiplexer back to its first position.
// - First conversion rise after data rise routes first channel, red when red-first.
// - Each later conversion clock rising edge advances to the next gain-stage output.
// - Conversion clock falling edge samples the multiplexer output into the converter.
// - Each converted sample reaches the output three conversion cycles later.
// - Input clamp stays disabled while sample-and-hold is selected.
// - Two-channel operation means exactly two channel-select bits set.
// - Leaving three-channel operation requires clearing the three-channel enable bit.
// - Two-channel pairs are red-green, red-blue or green-blue.
// - Order bit high converts earlier colour of pair first; low reverses.
// - Two-channel operation multiplexes only the two selected outputs in turn.
// - Gain and offset per colour load independently through registers.
// - Multiplexer sequence follows the ordering bit of the multiplexer register.
// - Multiplexer register has one select bit each for red, green, blue.
// - Order high runs red, green, blue; low runs blue, green, red.
// - Double sampling enable bit: set selects double sampling, clear sample-and-hold.
// - Three-channel enable set forces three-channel operation whatever the selects.
module ccm_sequencer #(
  parameter int unsigned LATENCY = ccm_pkg::CCM_LATENCY
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [ccm_pkg::CCM_ADDR_W-1:0] reg_addr,
  input wire logic [ccm_pkg::CCM_REG_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [ccm_pkg::CCM_REG_W-1:0] reg_rdata,
  // Sampling clocks from the timing controller.
  input wire ccm_pkg::ccm_clocks_t sample_clocks,
  // Channel levels from the sensor, red, green, blue by index.
  input wire logic [2:0][ccm_pkg::CCM_SAMPLE_W-1:0] channel_level,
  // Converter output stream.
  output ccm_pkg::ccm_word_t sample_out,
  output logic sample_valid,
  // Analog path controls.
  output ccm_pkg::ccm_chan_t mux_select,
  output logic clamp_enable,
  output ccm_pkg::ccm_trim_t channel_trim
);
  import ccm_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (LATENCY < 1 || LATENCY > CCM_PIPE_MAX) begin : g_bad_latency
    $error("LATENCY must lie between 1 and the pipeline capacity");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [8:0] cfg;
    logic [8:0] mux_cfg;
    ccm_trim_t trim;
    ccm_clocks_t prev;
    ccm_mux_state_t mux_state;
    logic [1:0] pos;
    ccm_chan_t mux_sel;
    logic [2:0][CCM_SAMPLE_W-1:0] ref_hold;
    logic [2:0][CCM_SAMPLE_W-1:0] pixel_hold;
    ccm_word_t [CCM_PIPE_MAX-1:0] pipe;
    ccm_word_t out;
    logic valid;
    logic clamp;
    logic [8:0] rdata;
  } ccm_state_t;

  ccm_state_t s;
  ccm_state_t next_s;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Turns the two configuration words into a conversion sequence.
  // An empty select field falls back to red alone so the converter never idles undefined.
  function automatic ccm_route_t decode_route(input logic [8:0] cfg, input logic [8:0] mux);
    ccm_route_t r;
    logic [2:0] en;
    int n;
    ccm_chan_t t;
    r = '0;
    n = 0;
    for (int c = 0; c < 3; c++) begin
      en[c] = mux[CCM_MUX_RED_BIT - c];
    end
    if (cfg[CCM_CFG_THREE_CH_BIT] || en == 3'b111) begin
      en = 3'b111;
    end else if (en == 3'b000) begin
      en = 3'b001;
    end
    // Ascending colour order gives red, green, blue and the pairs RG, RB, GB.
    for (int c = 0; c < 3; c++) begin
      if (en[c]) begin
        r.seq[n] = ccm_chan_t'(c[1:0]);
        n++;
      end
    end
    if (!mux[CCM_MUX_ORDER_BIT]) begin
      if (n == 3) begin
        t = r.seq[0];
        r.seq[0] = r.seq[2];
        r.seq[2] = t;
      end else if (n == 2) begin
        t = r.seq[0];
        r.seq[0] = r.seq[1];
        r.seq[1] = t;
      end
    end
    r.count = n[1:0];
    r.active = en;
    return r;
  endfunction : decode_route

  // Double sampling yields the swing between reference and data; it floors at zero.
  function automatic logic [CCM_SAMPLE_W-1:0] pixel_value(input logic correlated_double_sampling,
      input logic [CCM_SAMPLE_W-1:0] lvl, input logic [CCM_SAMPLE_W-1:0] ref_lvl);
    logic [CCM_SAMPLE_W-1:0] v;
    v = lvl;
    if (correlated_double_sampling) begin
      v = (lvl >= ref_lvl) ? (lvl - ref_lvl) : '0;
    end
    return v;
  endfunction : pixel_value

  // Step in the sequence, wrapping at the active count; a config change shrinking the
  // count is thus also caught by the wrap.
  function automatic logic [1:0] next_pos(input logic [1:0] p, input logic [1:0] n);
    logic [1:0] q;
    q = p + 2'h1;
    if (q >= n) begin
      q = 2'h0;
    end
    return q;
  endfunction : next_pos

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  ccm_route_t route;
  logic ref_fall;
  logic data_rise;
  logic data_fall;
  logic conv_rise;
  logic conv_fall;
  logic double_sampling_enable;

  // One process builds the whole next state so every field has a single driver.
  always_comb begin
    next_s = s;
    route = decode_route(s.cfg, s.mux_cfg);
    double_sampling_enable = s.cfg[CCM_CFG_DS_BIT];
    ref_fall = s.prev.reference_sample_clock && !sample_clocks.reference_sample_clock;
    data_rise = !s.prev.data_sample_clock && sample_clocks.data_sample_clock;
    data_fall = s.prev.data_sample_clock && !sample_clocks.data_sample_clock;
    conv_rise = !s.prev.conversion_clock && sample_clocks.conversion_clock;
    conv_fall = s.prev.conversion_clock && !sample_clocks.conversion_clock;
    next_s.prev = sample_clocks;
    next_s.valid = 1'b0;
    next_s.rdata = '0;

    // Register writes are the only way the mode changes; no pins steer it.
    if (reg_write) begin
      case (reg_addr)
        CCM_ADDR_CONFIG: next_s.cfg = reg_wdata & CCM_CFG_WMASK;
        CCM_ADDR_MUX_CONFIG: next_s.mux_cfg = reg_wdata & CCM_MUX_WMASK;
        CCM_ADDR_RED_GAIN: next_s.trim.gain[0] = reg_wdata[5:0];
        CCM_ADDR_GREEN_GAIN: next_s.trim.gain[1] = reg_wdata[5:0];
        CCM_ADDR_BLUE_GAIN: next_s.trim.gain[2] = reg_wdata[5:0];
        CCM_ADDR_RED_OFFSET: next_s.trim.offset[0] = reg_wdata & CCM_OFFSET_WMASK;
        CCM_ADDR_GREEN_OFFSET: next_s.trim.offset[1] = reg_wdata & CCM_OFFSET_WMASK;
        CCM_ADDR_BLUE_OFFSET: next_s.trim.offset[2] = reg_wdata & CCM_OFFSET_WMASK;
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; unmapped addresses read zero.
    if (reg_read) begin
      case (reg_addr)
        CCM_ADDR_CONFIG: next_s.rdata = s.cfg;
        CCM_ADDR_MUX_CONFIG: next_s.rdata = s.mux_cfg;
        CCM_ADDR_RED_GAIN: next_s.rdata = {3'h0, s.trim.gain[0]};
        CCM_ADDR_GREEN_GAIN: next_s.rdata = {3'h0, s.trim.gain[1]};
        CCM_ADDR_BLUE_GAIN: next_s.rdata = {3'h0, s.trim.gain[2]};
        CCM_ADDR_RED_OFFSET: next_s.rdata = s.trim.offset[0];
        CCM_ADDR_GREEN_OFFSET: next_s.rdata = s.trim.offset[1];
        CCM_ADDR_BLUE_OFFSET: next_s.rdata = s.trim.offset[2];
        CCM_ADDR_STATUS: next_s.rdata = {1'h0, route.count, s.pos, s.mux_state, s.mux_sel};
        default: next_s.rdata = '0;
      endcase
    end

    // Reference capture only counts in double sampling; in sample-and-hold the
    // controller holds that clock low, so no edge would arrive anyway.
    if (ref_fall && double_sampling_enable) begin
      for (int c = 0; c < 3; c++) begin
        if (route.active[c]) begin
          next_s.ref_hold[c] = channel_level[c];
        end
      end
    end

    // All active channels are caught in the same cycle so one pixel stays coherent.
    if (data_fall) begin
      for (int c = 0; c < 3; c++) begin
        if (route.active[c]) begin
          next_s.pixel_hold[c] = pixel_value(double_sampling_enable, channel_level[c], s.ref_hold[c]);
        end
      end
    end

    // Multiplexer sequencing; the data rise is applied last so it wins a collision.
    if (conv_rise) begin
      case (s.mux_state)
        CCM_MUX_ARMED: begin
          next_s.pos = 2'h0;
          next_s.mux_state = CCM_MUX_RUN;
        end
        CCM_MUX_RUN: begin
          if (route.count > 2'h1) begin
            next_s.pos = next_pos(s.pos, route.count);
          end else begin
            next_s.pos = 2'h0;
          end
        end
        CCM_MUX_IDLE: begin
          next_s.pos = 2'h0;
        end
        default: begin
          next_s.mux_state = CCM_MUX_IDLE;
        end
      endcase
    end
    if (data_rise) begin
      next_s.pos = 2'h0;
      next_s.mux_state = CCM_MUX_ARMED;
    end
    next_s.mux_sel = route.seq[next_s.pos];

    // Converter samples the selected output and the pipeline steps on the same edge.
    // The controller keeps data rises after the prior conversion fall, so the held pixel
    // is stable here.
    if (conv_fall) begin
      next_s.out = s.pipe[LATENCY-1];
      next_s.valid = 1'b1;
      for (int i = CCM_PIPE_MAX - 1; i > 0; i--) begin
        next_s.pipe[i] = s.pipe[i-1];
      end
      next_s.pipe[0].chan = s.mux_sel;
      next_s.pipe[0].value = s.pixel_hold[s.mux_sel];
    end

    // Clamp only makes sense against a reference level.
    next_s.clamp = double_sampling_enable;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.cfg <= CCM_CFG_RESET;
      s.mux_cfg <= CCM_MUX_RESET;
      s.mux_state <= CCM_MUX_IDLE;
      s.clamp <= CCM_CFG_RESET[CCM_CFG_DS_BIT];
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs, all taken from the state register
  // ****************************************************************
  assign reg_rdata = s.rdata;
  assign sample_out = s.out;
  assign sample_valid = s.valid;
  assign mux_select = s.mux_sel;
  assign clamp_enable = s.clamp;
  assign channel_trim = s.trim;

endmodule : ccm_sequencer

`default_nettype wire

//--- verilog/ccm_pkg.sv
// Purpose: Shared constants and types of the three-channel sampling and multiplex sequencer.
// Assumes: Nine-bit configuration words, sixteen-bit converter samples, one system clock.
// Notes: Register addresses are word indices on the plain register port.

// ****************************************************************
// Package
// ****************************************************************
package ccm_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int unsigned CCM_SAMPLE_W = 16;
  localparam int unsigned CCM_REG_W = 9;
  localparam int unsigned CCM_ADDR_W = 4;
  localparam int unsigned CCM_LATENCY = 3;
  localparam int unsigned CCM_PIPE_MAX = 8;
  localparam int unsigned CCM_NUM_CH = 3;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [3:0] CCM_ADDR_CONFIG = 4'h0;
  localparam logic [3:0] CCM_ADDR_MUX_CONFIG = 4'h1;
  localparam logic [3:0] CCM_ADDR_RED_GAIN = 4'h2;
  localparam logic [3:0] CCM_ADDR_GREEN_GAIN = 4'h3;
  localparam logic [3:0] CCM_ADDR_BLUE_GAIN = 4'h4;
  localparam logic [3:0] CCM_ADDR_RED_OFFSET = 4'h5;
  localparam logic [3:0] CCM_ADDR_GREEN_OFFSET = 4'h6;
  localparam logic [3:0] CCM_ADDR_BLUE_OFFSET = 4'h7;
  localparam logic [3:0] CCM_ADDR_STATUS = 4'h8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CCM_CFG_THREE_CH_BIT = 5;
  localparam int unsigned CCM_CFG_DS_BIT = 4;
  localparam int unsigned CCM_MUX_ORDER_BIT = 7;
  localparam int unsigned CCM_MUX_RED_BIT = 6;

  // ****************************************************************
  // Writable bits and values after reset
  // ****************************************************************
  localparam logic [8:0] CCM_CFG_WMASK = 9'h0fd;
  localparam logic [8:0] CCM_MUX_WMASK = 9'h0f0;
  localparam logic [8:0] CCM_GAIN_WMASK = 9'h03f;
  localparam logic [8:0] CCM_OFFSET_WMASK = 9'h1ff;
  localparam logic [8:0] CCM_CFG_RESET = 9'h0f8;
  localparam logic [8:0] CCM_MUX_RESET = 9'h080;
  localparam logic [8:0] CCM_TRIM_RESET = 9'h000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CCM_RED = 2'b00,
    CCM_GREEN = 2'b01,
    CCM_BLUE = 2'b10
  } ccm_chan_t;

  typedef enum logic [1:0] {
    CCM_MUX_IDLE = 2'b00,
    CCM_MUX_ARMED = 2'b01,
    CCM_MUX_RUN = 2'b10
  } ccm_mux_state_t;

  typedef struct packed {
    logic [1:0] count;
    logic [2:0] active;
    ccm_chan_t [2:0] seq;
  } ccm_route_t;

  typedef struct packed {
    ccm_chan_t chan;
    logic [CCM_SAMPLE_W-1:0] value;
  } ccm_word_t;

  typedef struct packed {
    logic [2:0][5:0] gain;
    logic [2:0][8:0] offset;
  } ccm_trim_t;

  typedef struct packed {
    logic reference_sample_clock;
    logic data_sample_clock;
    logic conversion_clock;
  } ccm_clocks_t;

endpackage : ccm_pkg

//--- test/ccm_seq_properties.sv
// Purpose: Port-level properties of the sampling and multiplex sequencer.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every sequencer instance; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Checker
// ****************************************************************
module ccm_seq_properties #(
  parameter int unsigned LATENCY = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [ccm_pkg::CCM_REG_W-1:0] reg_rdata,
  // Sampling side and outputs.
  input wire ccm_pkg::ccm_clocks_t sample_clocks,
  input wire ccm_pkg::ccm_word_t sample_out,
  input wire logic sample_valid,
  input wire ccm_pkg::ccm_chan_t mux_select,
  input wire logic clamp_enable,
  input wire ccm_pkg::ccm_trim_t channel_trim
);
  import ccm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Read data may only stand in the slot after a read strobe.
  rdata_slot_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  conv_fall_valid_a: assert property (
    $fell(sample_clocks.conversion_clock) |=> sample_valid)
    else $error("no output word after conversion fall");
  valid_cause_a: assert property (sample_valid |->
    $past(sample_clocks.conversion_clock, 2) && !$past(sample_clocks.conversion_clock))
    else $error("output word without conversion fall");
  valid_pulse_a: assert property (sample_valid |=> !sample_valid)
    else $error("valid longer than one cycle");
  out_hold_a: assert property (!sample_valid |-> $stable(sample_out))
    else $error("output word changed without valid");
  // The multiplexer moves only on a clock edge or a fresh configuration.
  mux_hold_a: assert property (!$rose(sample_clocks.conversion_clock)
    && !$rose(sample_clocks.data_sample_clock) && !reg_write && !$past(reg_write)
    |=> $stable(mux_select))
    else $error("multiplexer moved without cause");
  mux_legal_a: assert property ({mux_select} != 2'b11)
    else $error("illegal channel selected");
  trim_hold_a: assert property (!$past(reg_write) && !$past(reg_write, 2)
    |-> $stable(channel_trim))
    else $error("trim changed without a write");
  clamp_hold_a: assert property (!$past(reg_write) && !$past(reg_write, 2)
    |-> $stable(clamp_enable))
    else $error("clamp changed without a write");
  conv_cov_c: cover property ($fell(sample_clocks.conversion_clock) ##1 sample_valid);
  data_cov_c: cover property ($rose(sample_clocks.data_sample_clock));
  read_cov_c: cover property (reg_read ##1 reg_rdata != '0);
endmodule : ccm_seq_properties
bind ccm_sequencer ccm_seq_properties #(.LATENCY(LATENCY)) ccm_seq_properties_inst (
  .clk(clk), .rstn(rstn), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .sample_clocks(sample_clocks), .sample_out(sample_out),
  .sample_valid(sample_valid), .mux_select(mux_select), .clamp_enable(clamp_enable),
  .channel_trim(channel_trim));
`default_nettype wire

//--- test/ccm_timing_model.sv
// Purpose: Behavioural timing controller and sensor that feed one pixel per request.
// Assumes: Each clock level lasts two system clocks.
// Notes: Levels turn to the inverse of the data level once they may no longer be sampled.
`timescale 1ns/1ns
`default_nettype none
module ccm_timing_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pixel request.
  input wire logic go,
  input wire logic correlated_double_sampling,
  input wire logic [15:0] pix,
  // Sampling clocks and sensor levels.
  output ccm_pkg::ccm_clocks_t clocks,
  output logic [2:0][15:0] levels,
  output logic busy
);
  import ccm_pkg::*;
  localparam logic [15:0] REF_LVL = 16'h0100;
  logic [4:0] cnt;
  logic [3:0] ph;
  logic [2:0][15:0] data_lvl;
  // Ten phases of two clocks each: reference, data, then three conversions.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 5'h00;
      busy <= 1'b0;
    end else if (go) begin
      cnt <= 5'h00;
      busy <= 1'b1;
    end else if (busy) begin
      busy <= (cnt != 5'h13);
      cnt <= cnt + 5'h01;
    end
  end
  assign ph = cnt[4:1];
  // Data rises after the last conversion fall and drops before the next rise.
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      data_lvl[c] = REF_LVL + pix + 16'h1000 * 16'(c);
    end
    clocks.reference_sample_clock = busy && correlated_double_sampling && ph == 4'h0;
    clocks.data_sample_clock = busy && ph == 4'h2;
    clocks.conversion_clock = busy && ph >= 4'h4 && !ph[0];
    levels = (ph < 4'h2) ? {3{REF_LVL}} : ((ph < 4'h4) ? data_lvl : ~data_lvl);
  end
endmodule : ccm_timing_model
`default_nettype wire

//--- test/ccm_channel_mux_sequencer_tb_top.sv
// Purpose: Self-checking bench for registers, mode table and converter stream.
// Assumes: Reset between modes so each stream starts clean.
// Notes: The first three stream words after reset are pipeline fill and are skipped.
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, act, exp); end end
module ccm_channel_mux_sequencer_tb_top;
  import ccm_pkg::*;
  logic clk, rstn, reg_write, reg_read, sample_valid, clamp_enable, go, correlated_double_sampling, busy;
  logic [3:0] reg_addr;
  logic [8:0] reg_wdata, reg_rdata, rv;
  logic [15:0] pix;
  ccm_clocks_t sample_clocks;
  logic [2:0][15:0] channel_level;
  ccm_word_t sample_out;
  ccm_chan_t mux_select;
  ccm_trim_t channel_trim;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  ccm_word_t got[$];
  ccm_word_t exp_q[$];
  // Mode table: configuration, selects, channel count, packed order of channels.
  logic [8:0] cfg_tab [8] = '{9'h0f8, 9'h0f8, 9'h0e8, 9'h0d8, 9'h0c8, 9'h0d8, 9'h0c8, 9'h0d8};
  logic [8:0] mux_tab [8] = '{9'h080, 9'h000, 9'h060, 9'h0e0, 9'h030, 9'h0d0, 9'h020, 9'h010};
  int cnt_tab [8] = '{3, 3, 3, 2, 2, 2, 1, 1};
  logic [5:0] seq_tab [8] = '{6'h24, 6'h06, 6'h06, 6'h04, 6'h06, 6'h08, 6'h01, 6'h02};
  ccm_sequencer #(.LATENCY(3)) ccm_sequencer_inst (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sample_clocks(sample_clocks), .channel_level(channel_level),
    .sample_out(sample_out), .sample_valid(sample_valid), .mux_select(mux_select),
    .clamp_enable(clamp_enable), .channel_trim(channel_trim));
  ccm_timing_model ccm_timing_model_inst (.clk(clk), .rstn(rstn), .go(go), .correlated_double_sampling(correlated_double_sampling),
    .pix(pix), .clocks(sample_clocks), .levels(channel_level), .busy(busy));
  // Free-running clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      summarize();
    end
  end
  // Collect every converter word as it is announced.
  always @(posedge clk) begin
    if (sample_valid === 1'b1) got.push_back(sample_out);
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    got.delete();
  endtask : do_reset
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [8:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // One pixel from the timing model, waited for under a bound.
  task automatic pixel(input logic [15:0] p);
    @(posedge clk);
    pix <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (!busy) break;
    end
  endtask : pixel
  // Four pixels in one mode; stream words are checked against the mode table.
  task automatic run_mode(input int m);
    logic [1:0] ch;
    logic [15:0] v;
    do_reset();
    wr(CCM_ADDR_CONFIG, cfg_tab[m]);
    wr(CCM_ADDR_MUX_CONFIG, mux_tab[m]);
    @(negedge clk);
    `CHK(clamp_enable, cfg_tab[m][CCM_CFG_DS_BIT])
    correlated_double_sampling = cfg_tab[m][CCM_CFG_DS_BIT];
    exp_q.delete();
    for (int p = 0; p < 4; p++) begin
      pixel(16'h0011 * 16'(p + 1));
      for (int k = 0; k < 3; k++) begin
        ch = seq_tab[m][2 * (k % cnt_tab[m]) +: 2];
        v = 16'h0011 * 16'(p + 1) + 16'h1000 * 16'(ch) + (correlated_double_sampling ? 16'h0000 : 16'h0100);
        exp_q.push_back(ccm_word_t'({ch, v}));
      end
    end
    repeat (3) @(posedge clk);
    `CHK(mux_select, ch)
    `CHK(got.size(), 12)
    for (int i = 0; i < 9; i++) `CHK(got[i + 3], exp_q[i])
  endtask : run_mode
  // Register checks, then every mode of the table.
  initial begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 9'h000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    go = 1'b0;
    correlated_double_sampling = 1'b1;
    pix = 16'h0000;
    do_reset();
    rd(CCM_ADDR_CONFIG, rv);
    `CHK(rv, CCM_CFG_RESET)
    rd(CCM_ADDR_MUX_CONFIG, rv);
    `CHK(rv, CCM_MUX_RESET)
    wr(CCM_ADDR_RED_GAIN, 9'h1ff);
    wr(CCM_ADDR_GREEN_OFFSET, 9'h1a5);
    rd(CCM_ADDR_RED_GAIN, rv);
    `CHK(rv, 9'h03f)
    `CHK(channel_trim.gain[0], 6'h3f)
    `CHK(channel_trim.offset[1], 9'h1a5)
    `CHK(channel_trim.gain[1], 6'h00)
    rd(4'h9, rv);
    `CHK(rv, 9'h000)
    wr(CCM_ADDR_CONFIG, 9'h1ff);
    rd(CCM_ADDR_CONFIG, rv);
    `CHK(rv, 9'h0fd)
    for (int m = 0; m < 8; m++) run_mode(m);
    summarize();
  end
endmodule : ccm_channel_mux_sequencer_tb_top
`default_nettype wire
